//--- shared/isa_pkg.sv
// Package: constants and carriers for the input signal allocation block
package isa_pkg;

  // Register byte offsets
  localparam logic [7:0]  ISA_OFS_SEL_PEND   = 8'h00;
  localparam logic [7:0]  ISA_OFS_SEL_ACTIVE = 8'h04;
  localparam logic [7:0]  ISA_OFS_CTRL       = 8'h08;
  localparam logic [7:0]  ISA_OFS_STATUS     = 8'h0C;

  // Setting layout and limits
  localparam logic [15:0] ISA_SEL_RESET      = 16'h2100;
  localparam int          ISA_MODE_LSB       = 0;
  localparam int          ISA_SON_LSB        = 4;
  localparam logic [3:0]  ISA_MODE_MAX       = 4'h1;
  localparam logic [3:0]  ISA_MODE_DEFAULT   = 4'h0;

  // Servo-on mapping codes
  localparam logic [3:0]  ISA_SON_LOW_LAST   = 4'h6;
  localparam logic [3:0]  ISA_SON_FIX_ON     = 4'h7;
  localparam logic [3:0]  ISA_SON_FIX_OFF    = 4'h8;
  localparam logic [3:0]  ISA_SON_HIGH_FIRST = 4'h9;
  localparam logic [3:0]  ISA_SON_DEF_CODE   = 4'h0;

  // Control and status fields
  localparam int          ISA_CTRL_RESTART   = 0;
  localparam int          ISA_ST_SERVO_ON    = 0;
  localparam int          ISA_ST_PENDING     = 1;
  localparam int          ISA_ST_REJECT      = 2;
  localparam int          ISA_ST_LINES_LSB   = 8;
  localparam int          ISA_NUM_LINES      = 7;

  // Wishbone request and answer
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } isa_wb_req_t;

  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
  } isa_wb_rsp_t;

endpackage

//--- hw/isa_setting_store.sv
// Setting store: software copy and the copy applied at restart
`timescale 1ns/1ns
module isa_setting_store
(
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  // Update side
  input  wire logic        wr_en_i,
  input  wire logic [15:0] wr_data_i,
  input  wire logic        restart_i,
  // Stored values
  output logic [15:0]      pend_o,
  output logic [15:0]      active_o
);

  logic [15:0] pend_r;
  logic [15:0] active_r;

  // A new value waits in pend_r until a restart copies it across
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pend_r   <= isa_pkg::ISA_SEL_RESET;
      active_r <= isa_pkg::ISA_SEL_RESET;
    end
    else if (ce_i)
    begin
      if (wr_en_i)
        pend_r <= wr_data_i;
      if (restart_i)
        active_r <= pend_r;
    end
  end

  assign pend_o   = pend_r;
  assign active_o = active_r;

endmodule

//--- hw/isa_alloc_top.sv
// Input signal allocation: servo-on mapping behind a Wishbone register file
//
// Function
// - Setting is four hex digits, 0000..FFF1, resets to 2100, applies after restart.
// - Allocation mode 0 uses the built-in default pin, mapping digits ignored.
// - Codes 0..6: servo-on asserted while line 40 plus code is low.
// - Codes 9..F: servo-on asserted while line 40 plus code minus 9 is high.
// - Normal polarity: motor energized while the selected input is low.
// - Reverse polarity: motor stays off while the selected input is low.
//
// Register map, byte offsets on the bus:
//   0x00 pending setting, read and write; a write with mode digit above 1 is refused
//   0x04 applied setting, read only; only this copy steers the routing
//   0x08 control, write only, reads zero; bit 0 copies the pending setting across
//   0x0C status, read only: bit 0 servo-on, bit 1 pending differs from applied,
//        bit 2 last setting write refused (sticky until a good write),
//        bits 14:8 synchronised connector lines, bit 8 is line 40
//   Other offsets are acknowledged and read zero.
// Setting digits: [3:0] allocation mode, [7:4] servo-on code, [15:8] other functions.
// Input lines: bit 0 of in_lines_i is connector line 40, bit 6 is line 46.
// Timing: every access is acknowledged one cycle after it is taken; a line change
// reaches servo_on_o three enabled edges later (two sync flops, one decode flop).
// Reset: both copies return to 2100; servo_on_o stays low until the lines are seen.
// Clock enable: ce_i low freezes every register, synchronisers included.
// Limitation: only servo-on is allocated here; bits 15:8 are stored and read back
// for the functions that share the setting. A restart applies the whole word.
`timescale 1ns/1ns
module isa_alloc_top
(
  // Clock, reset, enable
  input  wire logic                clk_i,
  input  wire logic                rst_i,
  input  wire logic                ce_i,
  // Wishbone slave
  input  wire isa_pkg::isa_wb_req_t wb_req_i,
  output isa_pkg::isa_wb_rsp_t     wb_rsp_o,
  // Connector input lines 40..46, raw pin levels
  input  wire logic [6:0]          in_lines_i,
  // Allocated functions
  output logic                     servo_on_o,
  output logic                     alloc_mode_o
);

  // Servo-on decode from a mapping code and the synchronised lines.
  // Codes 0..6 pick a line read as active low, 9..F the same lines active high;
  // 7 and 8 ignore the pins, which lets a host run without wiring the input.
  function automatic logic son_decode(input logic [3:0] code, input logic [6:0] lines);
    logic [3:0] idx;
    idx = 4'h0;
    if (code <= isa_pkg::ISA_SON_LOW_LAST)
      son_decode = ~lines[code[2:0]];
    else if (code == isa_pkg::ISA_SON_FIX_ON)
      son_decode = 1'b1;
    else if (code == isa_pkg::ISA_SON_FIX_OFF)
      son_decode = 1'b0;
    else
    begin
      // Reverse-sense codes reuse the same seven lines, offset by 9
      idx        = code - isa_pkg::ISA_SON_HIGH_FIRST;
      son_decode = lines[idx[2:0]];
    end
  endfunction

  // Address match; kept in one place so a wider map changes a single line
  function automatic logic adr_hit(input logic [7:0] adr, input logic [7:0] ofs);
    adr_hit = adr == ofs;
  endfunction

  // Two-flop synchronisers for the connector pins. Both stages reset high, the
  // level of an open contact, so the first decode after reset sees no servo-on
  // request; a low that is already present shows three edges after release.
  logic [6:0] sync1_r;
  logic [6:0] sync2_r;

  genvar g;
  generate
    for (g = 0; g < isa_pkg::ISA_NUM_LINES; g = g + 1)
    begin : g_sync
      // One synchroniser per connector line
      always_ff @(posedge clk_i)
      begin
        if (rst_i)
        begin
          sync1_r[g] <= 1'b1;
          sync2_r[g] <= 1'b1;
        end
        else if (ce_i)
        begin
          sync1_r[g] <= in_lines_i[g];
          sync2_r[g] <= sync1_r[g];
        end
      end
    end
  endgenerate

  // Bus answer registers; ack and read data stand for one enabled cycle, longer while ce_i is low
  logic        ack_r;
  logic        ack_nxt;
  logic [31:0] rdat_r;
  logic [31:0] rdat_nxt;
  logic        reject_r;
  logic        reject_nxt;

  // Output registers
  logic        servo_on_r;
  logic        servo_on_nxt;
  logic        mode_r;
  logic        mode_nxt;

  // Setting store outputs: the pending copy written by software, and the copy
  // applied at restart that alone steers the routing
  logic [15:0] pend_w;
  logic [15:0] active_w;

  // Request decode. A request is taken only while ack is low, so a master that
  // keeps stb up through the ack cycle is not answered a second time.
  wire         req_w      = wb_req_i.cyc & wb_req_i.stb & ~ack_r;
  wire         wr_w       = req_w & wb_req_i.we;
  wire         hit_pend_w = adr_hit(wb_req_i.adr, isa_pkg::ISA_OFS_SEL_PEND);
  wire         hit_act_w  = adr_hit(wb_req_i.adr, isa_pkg::ISA_OFS_SEL_ACTIVE);
  wire         hit_ctrl_w = adr_hit(wb_req_i.adr, isa_pkg::ISA_OFS_CTRL);
  wire         hit_st_w   = adr_hit(wb_req_i.adr, isa_pkg::ISA_OFS_STATUS);

  // Byte-lane merge of a setting write; upper lanes have no storage.
  // A one-byte write keeps the other byte, and the range check sees the merged word.
  wire  [15:0] merged_w;
  assign merged_w[7:0]  = wb_req_i.sel[0] ? wb_req_i.dat[7:0]  : pend_w[7:0];
  assign merged_w[15:8] = wb_req_i.sel[1] ? wb_req_i.dat[15:8] : pend_w[15:8];

  // Only the mode digit is limited. A value whose mode digit is above 1 lies
  // outside 0000..FFF1 and is refused whole, so the stored copy never holds an
  // allocation mode that the routing does not know; the other digits are free.
  wire         in_range_w = merged_w[isa_pkg::ISA_MODE_LSB +: 4] <= isa_pkg::ISA_MODE_MAX;
  wire         set_wr_w   = wr_w & hit_pend_w & in_range_w;
  wire         set_bad_w  = wr_w & hit_pend_w & ~in_range_w;

  // Restart copies pending to applied at the take edge. A setting write cannot
  // fall in the same cycle, since only one request is taken at a time.
  wire         restart_w  = wr_w & hit_ctrl_w & wb_req_i.sel[0] & wb_req_i.dat[isa_pkg::ISA_CTRL_RESTART];

  // Pending and applied copies of the setting
  isa_setting_store u_store
  (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .ce_i      (ce_i),
    .wr_en_i   (set_wr_w),
    .wr_data_i (merged_w),
    .restart_i (restart_w),
    .pend_o    (pend_w),
    .active_o  (active_w)
  );

  // Allocation: only the applied setting steers the routing. Any mode digit other
  // than 0 counts as individual, though only 0 and 1 can ever be stored.
  wire  [3:0]  mode_digit_w = active_w[isa_pkg::ISA_MODE_LSB +: 4];
  wire  [3:0]  son_digit_w  = active_w[isa_pkg::ISA_SON_LSB +: 4];
  wire         indiv_w      = mode_digit_w != isa_pkg::ISA_MODE_DEFAULT;
  wire  [3:0]  son_code_w   = indiv_w ? son_digit_w
                                      : isa_pkg::ISA_SON_DEF_CODE;

  // Status word assembled from live state
  wire         pend_diff_w = pend_w != active_w;
  wire  [31:0] status_w;
  assign status_w[isa_pkg::ISA_ST_SERVO_ON] = servo_on_r;
  assign status_w[isa_pkg::ISA_ST_PENDING]  = pend_diff_w;
  assign status_w[isa_pkg::ISA_ST_REJECT]   = reject_r;
  assign status_w[7:3]                      = 5'h00;
  assign status_w[isa_pkg::ISA_ST_LINES_LSB +: isa_pkg::ISA_NUM_LINES] = sync2_r;
  assign status_w[31:15]                    = 17'h0_0000;

  // Read mux; unmapped offsets and the control word read as zero
  wire  [31:0] rd_mux_w = hit_pend_w ? {16'h0000, pend_w}   :
                          hit_act_w  ? {16'h0000, active_w} :
                          hit_st_w   ? status_w             :
                                       32'h0000_0000;

  // Servo path: the decoded request from the synchronised lines feeds the output
  // flop, so servo_on_o never glitches while a mapping code or a line changes
  wire         son_req_w    = son_decode(son_code_w, sync2_r);

  // Next-state assignments; read data is zero outside the ack cycle so a stale
  // word never lingers on the bus
  assign ack_nxt      = req_w;
  assign rdat_nxt     = (req_w & ~wb_req_i.we) ? rd_mux_w : 32'h0000_0000;
  // A refused write sets the flag; a good write clears it, set wins
  assign reject_nxt   = set_bad_w | (reject_r & ~set_wr_w);
  assign servo_on_nxt = son_req_w;
  assign mode_nxt     = indiv_w;

  // Registered bus answer and outputs;
  // ce_i low holds the answer too, so a master simply waits a little longer
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_r      <= 1'b0;
      rdat_r     <= 32'h0000_0000;
      reject_r   <= 1'b0;
      servo_on_r <= 1'b0;
      mode_r     <= 1'b1;
    end
    else if (ce_i)
    begin
      ack_r      <= ack_nxt;
      rdat_r     <= rdat_nxt;
      reject_r   <= reject_nxt;
      servo_on_r <= servo_on_nxt;
      mode_r     <= mode_nxt;
    end
  end

  // Ports come straight from the registers above
  assign wb_rsp_o.ack = ack_r;
  assign wb_rsp_o.dat = rdat_r;
  assign servo_on_o   = servo_on_r;
  assign alloc_mode_o = mode_r;

endmodule

//--- sim/isa_line_model.sv
// Partner model: contacts driving the seven connector lines
`timescale 1ns/1ns
module isa_line_model
(
  // Clock and wanted levels
  input  wire logic       clk_i,
  input  wire logic [6:0] lvl_i,
  // Lines, bit0 is line 40
  output logic [6:0]      lines_o = 7'h7f
);
  // Contacts switch after an edge, so no level lands on a sampling instant
  always @(posedge clk_i)
    lines_o <= lvl_i;
endmodule

//--- sim/isa_alloc_properties.sv
// Checker: bus answers and servo-on timing of the allocation block
`timescale 1ns/1ns
module isa_alloc_properties
(
  // Watched ports
  input wire logic                 clk_i,
  input wire logic                 rst_i,
  input wire logic                 ce_i,
  input wire isa_pkg::isa_wb_req_t wb_req_i,
  input wire isa_pkg::isa_wb_rsp_t wb_rsp_o,
  input wire logic [6:0]           in_lines_i,
  input wire logic                 servo_on_o,
  input wire logic                 alloc_mode_o
);
  logic [1:0] up_r;
  wire        req = wb_req_i.cyc && wb_req_i.stb;
  wire        ack = wb_rsp_o.ack;
  wire        rd  = ack && !wb_req_i.we;
  wire        rs8 = req && wb_req_i.we && wb_req_i.adr == isa_pkg::ISA_OFS_CTRL && wb_req_i.sel[0]
                    && wb_req_i.dat[isa_pkg::ISA_CTRL_RESTART];
  wire        unm = wb_req_i.adr[1:0] != 2'h0 || wb_req_i.adr > 8'h0c;
  // Sync flops hold reset levels at first, so line checks wait three edges
  always_ff @(posedge clk_i)
    if (rst_i)
      up_r <= 2'h0;
    else if (ce_i && up_r != 2'h3)
      up_r <= up_r + 2'h1;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_take; req && !ack && ce_i; endsequence
  sequence s_answer; ack ##1 !ack; endsequence
  a_ack_on_take: assert property (s_take |=> s_answer) else $error("no single ack");
  a_ack_has_req: assert property (ack |-> req && $past(req)) else $error("stray ack");
  a_idle_dat_zero: assert property (!ack |-> wb_rsp_o.dat == 32'h0000_0000) else $error("idle data");
  a_unmapped_zero: assert property (rd && unm |-> wb_rsp_o.dat == 32'h0000_0000) else $error("unmapped");
  a_ctrl_read_zero: assert property (rd && wb_req_i.adr == isa_pkg::ISA_OFS_CTRL |->
    wb_rsp_o.dat == 32'h0000_0000) else $error("ctrl read");
  a_release_state: assert property ($fell(rst_i) |-> !ack && !servo_on_o) else $error("release");
  // The line path only moves on enabled edges, so all three edges must have run
  a_default_line: assert property (up_r == 2'h3 && !alloc_mode_o && $past(alloc_mode_o, 3) == 1'b0
    && $past(ce_i) && $past(ce_i, 2) && $past(ce_i, 3)
    |-> servo_on_o == !$past(in_lines_i[0], 3)) else $error("default line");
  a_mode_by_restart: assert property (up_r == 2'h3 && $changed(alloc_mode_o) |-> rs8 || $past(rs8))
    else $error("mode changed alone");
endmodule
bind isa_alloc_top isa_alloc_properties u_props (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_req_i(wb_req_i),
  .wb_rsp_o(wb_rsp_o), .in_lines_i(in_lines_i), .servo_on_o(servo_on_o), .alloc_mode_o(alloc_mode_o));

//--- sim/tb_top.sv
// Testbench: setting store, restart and servo-on mapping
`timescale 1ns/1ns
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin failures++; $display("ERROR %0t got %h want %h", $time, a, b); end end
module tb_top;
  logic                 clk_i = 1'b0;
  logic                 rst_i = 1'b1;
  logic                 ce_i  = 1'b1;
  isa_pkg::isa_wb_req_t req   = '0;
  isa_pkg::isa_wb_rsp_t rsp;
  logic [6:0]           lvl   = 7'h7f;
  logic [6:0]           lines;
  logic                 son;
  logic                 amode;
  logic [31:0]          rd;
  int                   failures = 0;
  int                   n_compared = 0;
  // Clock and parts
  always #50 clk_i = ~clk_i;
  isa_line_model PEER (.clk_i(clk_i), .lvl_i(lvl), .lines_o(lines));
  isa_alloc_top DUT (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_req_i(req), .wb_rsp_o(rsp),
    .in_lines_i(lines), .servo_on_o(son), .alloc_mode_o(amode));
  task automatic give_verdict;
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // One classic cycle; request held until ack is seen at an edge
  task automatic wb(input logic w, input logic [7:0] a, input logic [15:0] d);
    int i;
    req <= '{1'b1, 1'b1, w, a, 4'h3, {16'h0000, d}};
    for (i = 0; i < 20; i++)
    begin
      @(posedge clk_i);
      if (rsp.ack === 1'b1)
        break;
    end
    rd = rsp.dat;
    if (i == 20)
    begin
      failures++;
      give_verdict();
    end
    req <= '0;
    @(posedge clk_i);
  endtask
  // Line change needs one partner edge plus three design edges
  task automatic setl(input logic [6:0] v);
    lvl <= v;
    repeat (5) @(posedge clk_i);
  endtask
  function automatic logic exp_son(input logic [3:0] c, input logic [6:0] l);
    if (c <= 4'h6)
      return !l[c[2:0]];
    if (c == 4'h7)
      return 1'b1;
    if (c == 4'h8)
      return 1'b0;
    return l[3'(c - 4'h9)];
  endfunction
  task automatic t_default;
    wb(1'b0, isa_pkg::ISA_OFS_SEL_ACTIVE, 16'h0000);
    `CHK(rd[15:0], 16'h2100)
    wb(1'b1, isa_pkg::ISA_OFS_SEL_PEND, 16'h2170);
    wb(1'b1, isa_pkg::ISA_OFS_CTRL, 16'h0001);
    setl(7'h7e);
    `CHK(son, 1'b1)
    setl(7'h01);
    `CHK(son, 1'b0)
    `CHK(amode, 1'b0)
  endtask
  // Every mapping code, each line seen low and high
  task automatic t_codes;
    for (int c = 0; c < 16; c++)
    begin
      wb(1'b1, isa_pkg::ISA_OFS_SEL_PEND, {8'h21, 4'(c), 4'h1});
      wb(1'b1, isa_pkg::ISA_OFS_CTRL, 16'h0001);
      setl(7'h55);
      `CHK(son, exp_son(4'(c), 7'h55))
      setl(7'h2a);
      `CHK(son, exp_son(4'(c), 7'h2a))
    end
    `CHK(amode, 1'b1)
  endtask
  // Out-of-range write kept out; new value waits for restart
  task automatic t_store;
    wb(1'b1, isa_pkg::ISA_OFS_SEL_PEND, 16'h2102);
    wb(1'b0, isa_pkg::ISA_OFS_STATUS, 16'h0000);
    `CHK(rd[2], 1'b1)
    wb(1'b1, isa_pkg::ISA_OFS_SEL_PEND, 16'h2101);
    wb(1'b0, isa_pkg::ISA_OFS_STATUS, 16'h0000);
    `CHK(rd[15:0], ({1'b0, 7'h2a, 5'h00, 1'b0, 1'b1, exp_son(4'hf, 7'h2a)}))
    wb(1'b0, isa_pkg::ISA_OFS_SEL_ACTIVE, 16'h0000);
    `CHK(rd[15:0], 16'h21f1)
    wb(1'b0, isa_pkg::ISA_OFS_SEL_PEND, 16'h0000);
    `CHK(rd[15:0], 16'h2101)
    wb(1'b0, isa_pkg::ISA_OFS_CTRL, 16'h0000);
    `CHK(rd, 32'h0000_0000)
    wb(1'b0, 8'h10, 16'h0000);
    `CHK(rd, 32'h0000_0000)
    wb(1'b1, isa_pkg::ISA_OFS_CTRL, 16'h0001);
    wb(1'b0, isa_pkg::ISA_OFS_STATUS, 16'h0000);
    `CHK(rd[1], 1'b0)
  endtask
  // Reset in mid-run returns both copies to the default setting
  task automatic t_rerst;
    rst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    wb(1'b0, isa_pkg::ISA_OFS_SEL_ACTIVE, 16'h0000);
    `CHK(rd[15:0], 16'h2100)
    wb(1'b0, isa_pkg::ISA_OFS_SEL_PEND, 16'h0000);
    `CHK(rd[15:0], 16'h2100)
    `CHK(amode, 1'b0)
  endtask
  // Clock enable low freezes the routing; it resumes once enabled again
  task automatic t_freeze;
    setl(7'h7e);
    `CHK(son, 1'b1)
    ce_i <= 1'b0;
    lvl  <= 7'h7f;
    repeat (5) @(posedge clk_i);
    `CHK(son, 1'b1)
    ce_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    `CHK(son, 1'b0)
  endtask
  // Main sequence
  initial
  begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_default();
    t_codes();
    t_store();
    t_rerst();
    t_freeze();
    give_verdict();
  end
endmodule
